// ### design/lsc_pkg.sv
// lsc_pkg: constants and types for the line shading correction block
package lsc_pkg;
  // ************************************************************
  // pixel and bus carriers
  // ************************************************************
  localparam int LSC_PIX_W = 12;
  typedef struct packed {
    logic [LSC_PIX_W-1:0] r;
    logic [LSC_PIX_W-1:0] g;
    logic [LSC_PIX_W-1:0] b;
  } lsc_pixel_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } lsc_apb_req_t;
  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] LSC_OFF_CTRL = 8'h00;
  localparam logic [7:0] LSC_OFF_CMD = 8'h04;
  localparam logic [7:0] LSC_OFF_RESULT = 8'h08;
  localparam logic [7:0] LSC_OFF_REGION = 8'h0c;
  localparam logic [7:0] LSC_OFF_SELECT = 8'h10;
  localparam logic [7:0] LSC_OFF_GAIN = 8'h14;
  localparam logic [7:0] LSC_OFF_IRQ_STS = 8'h18;
  localparam logic [7:0] LSC_OFF_IRQ_MSK = 8'h1c;
  // ************************************************************
  // field positions, codes, reset values
  // ************************************************************
  localparam int LSC_CTRL_AREA_LSB = 2;
  localparam int LSC_CMD_CAL_BIT = 0;
  localparam int LSC_CMD_SAVE_BIT = 1;
  localparam int LSC_REG_WIDTH_LSB = 16;
  localparam int LSC_SEL_CH_LSB = 16;
  localparam int LSC_RES_BUSY_BIT = 8;
  typedef enum logic [1:0] {
    LSC_FLAT_FULL = 2'h0,
    LSC_FLAT_USER_BE = 2'h1,
    LSC_COLOR_FULL = 2'h2,
    LSC_COLOR_USER_BE = 2'h3
  } lsc_mode_t;
  localparam logic [1:0] LSC_AREA_OFF = 2'h0;
  localparam logic [1:0] LSC_AREA_RST = 2'h1;
  localparam logic [2:0] LSC_RES_NONE = 3'h0;
  localparam logic [2:0] LSC_RES_OK = 3'h1;
  localparam logic [2:0] LSC_RES_OK_BE = 3'h2;
  localparam logic [2:0] LSC_RES_ERR1 = 3'h3;
  localparam logic [2:0] LSC_RES_ERR2 = 3'h4;
  localparam logic [2:0] LSC_RES_ERR3 = 3'h5;
  localparam int LSC_IRQ_DONE = 0;
  localparam int LSC_IRQ_FAIL = 1;
  localparam int LSC_IRQ_SAVE = 2;
  localparam logic [15:0] LSC_UNITY = 16'h4000;
  localparam int LSC_FRAC = 14;
  localparam int LSC_CLK_HZ = 10_000_000;
  localparam int LSC_CAL_WAIT_MS = 50;
  localparam int LSC_CAL_WAIT_CYC = LSC_CAL_WAIT_MS * (LSC_CLK_HZ / 1000);
endpackage : lsc_pkg

// ### design/lsc_top.sv
// lsc_top: line shading correction with calibration and apb registers
// Behaviour
// - flat modes: brightest level is the reference
// - colour modes: red, blue follow green profile
// - correction applies over the full line width
// - full-area modes abort when too bright/dark
// - best-effort modes use user region, never abort; colour best-effort ignores the region
// - best-effort calibration ends within bounded time
// - one coefficient per two-pixel block, indexable
// - four correction modes, flat full after reset
// - three storage areas plus off
// - success stores coefficients, reports success
// - too bright gives Error1, too dark Error2
// - best effort stores, reports best-effort success
// - selected block gain readable/writable, 0x4000 unity
// - gain write immediate; area change discards edits
// - save command copies active set to area
// - calibrate refused with Error3 when not allowed
//
// The implementer's own choices: the address map and the APB slave port.
module lsc_top
  import lsc_pkg::*;
#(
  parameter int NUM_BLOCKS = 64,
  parameter bit COLOR_MODEL = 1'b1,
  parameter int CAL_WAIT_CYC = LSC_CAL_WAIT_CYC,
  parameter int BRIGHT_SUM = 8160,
  parameter int DARK_SUM = 256
) (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset
  input wire logic ce, // clock enable
  input wire lsc_pkg::lsc_apb_req_t apb_req, // apb request
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic acquisition_begin, // acquisition running
  input wire logic pattern_output, // test pattern active
  input wire logic pix_valid, // pixel valid
  input wire logic pix_sol, // first pixel of line
  input wire lsc_pkg::lsc_pixel_t pix_in, // input pixel
  output lsc_pkg::lsc_pixel_t pix_out, // corrected pixel
  output logic pix_out_valid, // corrected pixel valid
  output logic irq // interrupt level
);
  import lsc_pkg::*;
  localparam int BW = $clog2(NUM_BLOCKS);
  localparam int NE = 3 * NUM_BLOCKS;
  localparam int SW = LSC_PIX_W + 1;
  localparam int DW = SW + LSC_FRAC;
  localparam int CW = $clog2(DW + 1);
  localparam int TW = $clog2(CAL_WAIT_CYC + 1);
  localparam logic [BW:0] LAST_POS = (BW + 1)'(2 * NUM_BLOCKS - 1);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CAPT = 5'b00010,
    ST_DIV = 5'b00100,
    ST_STORE = 5'b01000,
    ST_LOAD = 5'b10000
  } lsc_state_t;

  // ************************************************************
  // registers and storage
  // ************************************************************
  lsc_state_t st_q;
  lsc_mode_t mode_q;
  logic [1:0] area_q;
  logic [2:0] result_q, res_pend_q;
  logic [15:0] reg_off_q, reg_width_q, blk_idx_q;
  logic [1:0] chan_q;
  logic [2:0] sts_q, msk_q;
  logic [15:0] coef_q [NE];
  logic [15:0] store_q [3*NE];
  logic [SW-1:0] line_q [NE];
  logic [SW-1:0] max_q [3];
  logic [1:0] ch_q;
  logic [BW-1:0] blk_q;
  logic [BW:0] pos_q;
  logic capt_on_q, div_run_q;
  logic [CW-1:0] div_cnt_q;
  logic [DW-1:0] div_n_q, div_q_q;
  logic [SW:0] div_r_q;
  logic [TW-1:0] tmo_q;
  logic pready_q, pslverr_q, irq_q, pout_v_q;
  logic [31:0] prdata_q;
  lsc_pixel_t pout_q;

  // ************************************************************
  // apb decode
  // ************************************************************
  wire acc = apb_req.psel & apb_req.penable;
  wire done = acc & pready_q;
  wire wr = done & apb_req.pwrite;
  wire idle = st_q == ST_IDLE;
  wire a_ctrl = apb_req.paddr == LSC_OFF_CTRL;
  wire a_cmd = apb_req.paddr == LSC_OFF_CMD;
  wire a_res = apb_req.paddr == LSC_OFF_RESULT;
  wire a_reg = apb_req.paddr == LSC_OFF_REGION;
  wire a_sel = apb_req.paddr == LSC_OFF_SELECT;
  wire a_gain = apb_req.paddr == LSC_OFF_GAIN;
  wire a_sts = apb_req.paddr == LSC_OFF_IRQ_STS;
  wire a_msk = apb_req.paddr == LSC_OFF_IRQ_MSK;
  wire mapped = a_ctrl | a_cmd | a_res | a_reg | a_sel | a_gain
      | a_sts | a_msk;
  wire [31:0] wd = apb_req.pwdata;
  wire [1:0] wd_mode = wd[1:0];
  wire [1:0] wd_area = wd[LSC_CTRL_AREA_LSB +: 2];
  // colour modes exist only on the colour model
  wire mode_ok = COLOR_MODEL | ~wd_mode[1];
  wire [31:0] sel_idx32 = 32'(chan_q) * NUM_BLOCKS + 32'(blk_idx_q);
  wire sel_ok = chan_q != 2'h3 && blk_idx_q < 16'(NUM_BLOCKS);
  wire [15:0] sel_gain = sel_ok ? coef_q[sel_idx32] : 16'h0000;
  wire cal_cmd = wr & a_cmd & wd[LSC_CMD_CAL_BIT] & idle;
  wire save_cmd = wr & a_cmd & wd[LSC_CMD_SAVE_BIT] & idle
      & ~wd[LSC_CMD_CAL_BIT];
  wire cal_refuse = ~acquisition_begin | pattern_output
      | area_q == LSC_AREA_OFF;
  // area change only while idle; reloads and drops unsaved edits
  wire area_chg = wr & a_ctrl & idle & wd_area != area_q
      & wd_area != LSC_AREA_OFF;
  wire gain_wr = wr & a_gain & idle & sel_ok;
  wire is_be = mode_q == LSC_FLAT_USER_BE
      || mode_q == LSC_COLOR_USER_BE;
  wire is_color = mode_q[1];

  logic [31:0] prdata_d;
  always_comb begin
    case (1'b1)
      a_ctrl: prdata_d = {28'h0, area_q, mode_q};
      a_res: prdata_d = {23'h0, ~idle, 5'h0, result_q};
      a_reg: prdata_d = {reg_width_q, reg_off_q};
      a_sel: prdata_d = {14'h0, chan_q, blk_idx_q};
      a_gain: prdata_d = {16'h0, sel_gain};
      a_sts: prdata_d = {29'h0, sts_q};
      a_msk: prdata_d = {29'h0, msk_q};
      default: prdata_d = 32'h0;
    endcase
  end

  // one wait state so every bus answer leaves a flip-flop
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else if (ce) begin
      pready_q <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~mapped;
      prdata_q <= (acc & ~pready_q) ? prdata_d : 32'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= LSC_FLAT_FULL;
      area_q <= LSC_AREA_RST;
      reg_off_q <= 16'h0;
      reg_width_q <= 16'(2 * NUM_BLOCKS);
      chan_q <= 2'h0;
      blk_idx_q <= 16'h0;
      msk_q <= 3'h0;
    end else if (ce && wr) begin
      if (a_ctrl && idle && mode_ok) mode_q <= lsc_mode_t'(wd_mode);
      if (a_ctrl && idle) area_q <= wd_area;
      if (a_reg) reg_off_q <= wd[15:0];
      if (a_reg) reg_width_q <= wd[LSC_REG_WIDTH_LSB +: 16];
      if (a_sel) chan_q <= wd[LSC_SEL_CH_LSB +: 2];
      if (a_sel) blk_idx_q <= wd[15:0];
      if (a_msk) msk_q <= wd[2:0];
    end
  end

  // ************************************************************
  // pixel path
  // ************************************************************
  wire [BW-1:0] pix_blk = pix_sol ? '0 : pos_q[BW:1];
  logic [LSC_PIX_W-1:0] pin_c [3];
  logic [LSC_PIX_W-1:0] pout_c [3];
  assign pin_c[0] = pix_in.r;
  assign pin_c[1] = pix_in.g;
  assign pin_c[2] = pix_in.b;
  for (genvar c = 0; c < 3; c++) begin : g_ch
    wire [15:0] k = coef_q[c*NUM_BLOCKS + int'(pix_blk)];
    wire [LSC_PIX_W+15:0] prod = {16'h0, pin_c[c]} * {12'h0, k};
    wire [LSC_PIX_W+1:0] shf = prod[LSC_PIX_W+15:LSC_FRAC];
    // clip instead of wrapping to avoid dark spots in hot areas
    assign pout_c[c] = |shf[LSC_PIX_W+1:LSC_PIX_W] ? '1
        : shf[LSC_PIX_W-1:0];
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= '0;
      pout_q <= '0;
      pout_v_q <= 1'b0;
    end else if (ce) begin
      pout_v_q <= pix_valid;
      if (pix_valid) pout_q <= '{pout_c[0], pout_c[1], pout_c[2]};
      if (pix_valid) pos_q <= pix_sol ? (BW + 1)'(1)
          : (pos_q == LAST_POS ? '0 : pos_q + 1'b1);
    end
  end

  // ************************************************************
  // calibration engine
  // ************************************************************
  wire [BW:0] cur_pos = pix_sol ? '0 : pos_q;
  wire in_reg = !is_be || (16'(cur_pos) >= reg_off_q
      && 16'(cur_pos) < reg_off_q + reg_width_q);
  wire capt_px = st_q == ST_CAPT && pix_valid && (capt_on_q | pix_sol);
  wire line_end = capt_px && cur_pos == LAST_POS;
  // the last green block is still being summed when the line ends
  wire [SW-1:0] g_last = line_q[NUM_BLOCKS + int'(cur_pos[BW:1])]
      + SW'(pin_c[1]);
  wire [SW-1:0] ref_max = (line_end && g_last > max_q[1]) ? g_last
      : max_q[1];
  wire too_bright = ref_max >= SW'(BRIGHT_SUM);
  wire too_dark = ref_max < SW'(DARK_SUM);
  wire [31:0] eidx = 32'(ch_q) * NUM_BLOCKS + 32'(blk_q);
  wire [31:0] gidx = NUM_BLOCKS + 32'(blk_q);
  wire [31:0] aidx = 32'(area_q - 2'h1) * NE + eidx;
  wire last_e = ch_q == 2'h2 && blk_q == BW'(NUM_BLOCKS - 1);
  wire div_green = is_color && ch_q == 2'h1; // reference stays unity
  // colour: block green over block channel; flat: channel peak
  wire [SW-1:0] num = is_color ? line_q[gidx]
      : max_q[ch_q];
  wire [SW-1:0] den = line_q[eidx];
  wire [SW:0] div_t = {div_r_q[SW-1:0], div_n_q[DW-1]};
  wire div_ge = div_t >= {1'b0, den};
  wire div_end = div_run_q && div_cnt_q == CW'(DW - 1);
  wire [DW-1:0] q_fin = {div_q_q[DW-2:0], div_ge};
  wire [15:0] gain_new = (den == '0 || |q_fin[DW-1:16]) ? 16'hffff
      : q_fin[15:0];
  wire tmo_hit = tmo_q == TW'(CAL_WAIT_CYC);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      result_q <= LSC_RES_NONE;
      res_pend_q <= LSC_RES_NONE;
      ch_q <= 2'h0;
      blk_q <= '0;
      capt_on_q <= 1'b0;
      div_run_q <= 1'b0;
      div_cnt_q <= '0;
      div_n_q <= '0;
      div_q_q <= '0;
      div_r_q <= '0;
      tmo_q <= '0;
      for (int i = 0; i < 3; i++) max_q[i] <= '0;
    end else if (ce) begin
      case (st_q)
        ST_IDLE: begin
          ch_q <= 2'h0;
          blk_q <= '0;
          tmo_q <= '0;
          capt_on_q <= 1'b0;
          if (cal_cmd && cal_refuse) begin
            result_q <= LSC_RES_ERR3;
          end else if (cal_cmd) begin
            st_q <= ST_CAPT;
            for (int i = 0; i < 3; i++) max_q[i] <= '0;
          end else if (save_cmd && area_q != LSC_AREA_OFF) begin
            res_pend_q <= LSC_RES_NONE; // a plain save keeps the result
            st_q <= ST_STORE;
          end else if (area_chg) begin
            st_q <= ST_LOAD;
          end
        end
        ST_CAPT: begin
          tmo_q <= tmo_q + 1'b1;
          if (capt_px) capt_on_q <= 1'b1;
          for (int c = 0; c < 3; c++) begin
            if (capt_px && cur_pos[0] && in_reg
                && line_q[c*NUM_BLOCKS + int'(cur_pos[BW:1])]
                + SW'(pin_c[c]) > max_q[c])
              max_q[c] <= line_q[c*NUM_BLOCKS + int'(cur_pos[BW:1])]
                  + SW'(pin_c[c]);
          end
          if (tmo_hit) begin
            // keep present set as the nearest result obtainable
            res_pend_q <= is_be ? LSC_RES_OK_BE : LSC_RES_ERR2;
            st_q <= is_be ? ST_STORE : ST_IDLE;
            if (!is_be) result_q <= LSC_RES_ERR2;
          end else if (line_end) begin
            if (is_be) begin
              res_pend_q <= LSC_RES_OK_BE;
              st_q <= ST_DIV;
            end else if (too_bright || too_dark) begin
              result_q <= too_bright ? LSC_RES_ERR1
                  : LSC_RES_ERR2;
              st_q <= ST_IDLE;
            end else begin
              res_pend_q <= LSC_RES_OK;
              st_q <= ST_DIV;
            end
          end
        end
        ST_DIV: begin
          if (!div_run_q && !div_green) begin
            div_run_q <= 1'b1;
            div_cnt_q <= '0;
            div_n_q <= {num, {LSC_FRAC{1'b0}}};
            div_r_q <= '0;
            div_q_q <= '0;
          end else if (div_run_q && !div_end) begin
            div_cnt_q <= div_cnt_q + 1'b1;
            div_n_q <= {div_n_q[DW-2:0], 1'b0};
            div_r_q <= div_ge ? div_t - {1'b0, den} : div_t;
            div_q_q <= q_fin;
          end else begin
            div_run_q <= 1'b0;
            blk_q <= blk_q == BW'(NUM_BLOCKS - 1) ? '0 : blk_q + 1'b1;
            if (blk_q == BW'(NUM_BLOCKS - 1)) ch_q <= ch_q + 1'b1;
            if (last_e) st_q <= ST_STORE;
          end
        end
        ST_STORE, ST_LOAD: begin
          blk_q <= blk_q == BW'(NUM_BLOCKS - 1) ? '0 : blk_q + 1'b1;
          if (blk_q == BW'(NUM_BLOCKS - 1)) ch_q <= ch_q + 1'b1;
          if (last_e) begin
            st_q <= ST_IDLE;
            if (st_q == ST_STORE && res_pend_q != LSC_RES_NONE)
              result_q <= res_pend_q;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // coefficient set: edits, results and reloads share one writer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NE; i++) coef_q[i] <= LSC_UNITY;
    end else if (ce) begin
      if (gain_wr) coef_q[sel_idx32] <= wd[15:0];
      if (st_q == ST_DIV && div_green) coef_q[eidx] <= LSC_UNITY;
      if (div_end) coef_q[eidx] <= gain_new;
      if (st_q == ST_LOAD) coef_q[eidx] <= store_q[aidx];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 3 * NE; i++) store_q[i] <= LSC_UNITY;
      for (int i = 0; i < NE; i++) line_q[i] <= '0;
    end else if (ce) begin
      if (st_q == ST_STORE) store_q[aidx] <= coef_q[eidx];
      for (int c = 0; c < 3; c++) begin
        if (capt_px)
          line_q[c*NUM_BLOCKS + int'(cur_pos[BW:1])] <= cur_pos[0]
              ? line_q[c*NUM_BLOCKS + int'(cur_pos[BW:1])]
              + SW'(pin_c[c]) : SW'(pin_c[c]);
      end
    end
  end

  // ************************************************************
  // interrupts
  // ************************************************************
  logic [2:0] ev;
  always_comb begin
    ev = 3'h0;
    ev[LSC_IRQ_DONE] = st_q == ST_STORE && last_e
        && (res_pend_q == LSC_RES_OK || res_pend_q == LSC_RES_OK_BE);
    ev[LSC_IRQ_FAIL] = (cal_cmd && cal_refuse)
        || (st_q == ST_CAPT && !is_be
        && (tmo_hit || (line_end && (too_bright || too_dark))));
    ev[LSC_IRQ_SAVE] = st_q == ST_STORE && last_e;
  end
  wire [2:0] sts_clr = (wr && a_sts) ? wd[2:0] : 3'h0;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sts_q <= 3'h0;
      irq_q <= 1'b0;
    end else if (ce) begin
      sts_q <= (sts_q & ~sts_clr) | ev; // set beats clear
      irq_q <= |((sts_q & ~sts_clr | ev) & msk_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pix_out = pout_q;
  assign pix_out_valid = pout_v_q;
  assign irq = irq_q;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  refuse_err3_a: assert property (
    ce && cal_cmd && area_q == LSC_AREA_OFF |=> result_q == LSC_RES_ERR3)
    else $error("refused calibrate did not give Error3");
  mode_legal_a: assert property (
    ce && wr && a_ctrl && idle && mode_ok |=> mode_q == $past(wd_mode))
    else $error("mode select not taken");
  gain_edit_a: assert property (
    ce && gain_wr |=> coef_q[$past(sel_idx32)] == $past(wd[15:0]))
    else $error("gain write not applied at once");
  save_start_a: assert property (
    ce && save_cmd && area_q != LSC_AREA_OFF |=> st_q == ST_STORE)
    else $error("save command did not start copy");
  be_code_a: assert property (
    ce && $changed(result_q) && result_q == LSC_RES_OK_BE |-> is_be)
    else $error("best-effort code outside best-effort mode");
  full_err_a: assert property (
    ce && $changed(result_q) && (result_q == LSC_RES_ERR1
    || result_q == LSC_RES_ERR1 + 3'h1) |-> !is_be)
    else $error("image error reported in best-effort mode");
  succ_store_a: assert property (
    ce && $changed(result_q) && result_q == LSC_RES_OK
    |-> $past(st_q) == ST_STORE)
    else $error("success without storing coefficients");
  cal_bound_a: assert property (
    st_q == ST_CAPT |-> tmo_q <= TW'(CAL_WAIT_CYC))
    else $error("calibration wait overran its bound");
  sat_clip_a: assert property (
    ce && pix_valid && pix_in.g == '1 && g_ch[1].k >= LSC_UNITY
    |=> pix_out.g == '1)
    else $error("full-scale pixel not held at maximum");
  out_follow_a: assert property (
    ce |=> pix_out_valid == $past(pix_valid))
    else $error("pixel valid not passed through");
  cal_ok_c: cover property (result_q == LSC_RES_OK);
  cal_be_c: cover property (result_q == LSC_RES_OK_BE);
  cal_err3_c: cover property (result_q == LSC_RES_ERR3);
endmodule : lsc_top

// ### test/lsc_sensor_model.sv
// lsc_sensor_model: line-scan sensor sending bursts of whole lines
module lsc_sensor_model
  import lsc_pkg::*;
#(
  parameter int LINE = 16
) (
  input wire logic clk_sys, // clock
  input wire logic start, // begin a burst
  input wire logic [7:0] nlines, // lines per burst
  input wire lsc_pkg::lsc_pixel_t level, // scene brightness
  output logic pix_valid, // pixel valid
  output logic pix_sol, // first pixel of line
  output lsc_pkg::lsc_pixel_t pix_in // pixel value
);
  int left = 0;
  initial begin
    pix_valid = 1'b0;
    pix_sol = 1'b0;
    pix_in = '0;
  end
  always @(posedge clk_sys) begin
    if (start)
      left <= nlines * LINE;
    else if (left > 0)
      left <= left - 1;
    pix_valid <= left > 0 && !start;
    pix_sol <= left > 0 && !start && left % LINE == 0;
    // idle data toggles so a stale sample never looks like a pixel
    pix_in <= (left > 0 && !start) ? level : ~pix_in;
  end
endmodule : lsc_sensor_model

// ### test/lsc_top_tb_top.sv
// lsc_top_tb_top: self-checking bench for the line shading block
module lsc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lsc_pkg::*;
  localparam int NB = 8;
  localparam int LW = 2 * NB;
  typedef struct {bit c; logic [31:0] v; logic e;} lsc_note_t;
  logic clk_sys = 0, arst_n = 0, start = 0, acq = 0, pat = 0;
  logic pready, pslverr, irq, pv, ps, pov;
  logic [31:0] prdata, q;
  logic [7:0] nl = 8'h01;
  logic [15:0] gain [3][NB];
  lsc_apb_req_t req = '0;
  lsc_pixel_t pin, pout, lvl = '0;
  lsc_note_t rq[$], nt;
  lsc_pixel_t pq[$];
  int mismatches = 0, checked = 0, cyc = 0;
  lsc_top #(.NUM_BLOCKS(NB), .CAL_WAIT_CYC(2000)) lsc_top_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acquisition_begin(acq), .pattern_output(pat), .pix_valid(pv),
    .pix_sol(ps), .pix_in(pin), .pix_out(pout), .pix_out_valid(pov),
    .irq(irq));
  lsc_sensor_model #(.LINE(LW)) lsc_sensor_model_i (.clk_sys(clk_sys),
    .start(start), .nlines(nl), .level(lvl), .pix_valid(pv),
    .pix_sol(ps), .pix_in(pin));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // ****************************************
  // checking and bus tasks
  // ****************************************
  task automatic fail(input string m);
    mismatches++;
    $display("ERROR %0t %s", $time, m);
  endtask : fail
  task automatic cmp_reg(input logic [31:0] g, input logic ge, input lsc_note_t n);
    checked++;
    if (g !== n.v || ge !== n.e) fail("register read");
  endtask : cmp_reg
  task automatic cmp_pix(input lsc_pixel_t g, input lsc_pixel_t e);
    checked++;
    if (g !== e) fail("corrected pixel");
  endtask : cmp_pix
  task automatic cmp_bit(input logic g, input logic e);
    checked++;
    if (g !== e) fail("flag");
  endtask : cmp_bit
  task automatic wrap_up();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input bit c = 0, input logic [31:0] ev = '0, input logic ee = 0);
    rq.push_back('{c, ev, ee});
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    req <= '0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic area(input logic [31:0] d);
    wr(LSC_OFF_CTRL, d);
    // an area change reloads the set; edits are refused until it ends
    repeat (3 * NB + 2) @(posedge clk_sys);
  endtask : area
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee = 0);
    apb(1'b0, a, '0, 1, e, ee);
  endtask : rd
  task automatic burst(input logic [7:0] n, input lsc_pixel_t v);
    nl <= n;
    lvl <= v;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
  endtask : burst
  function automatic logic [11:0] sat(input logic [11:0] v, input logic [15:0] g);
    logic [27:0] m;
    m = (v * g) >> 14;
    return (m > 28'hfff) ? 12'hfff : m[11:0];
  endfunction : sat
  task automatic cal(input logic [1:0] m, input logic [11:0] v,
                     input logic [2:0] e, input logic [7:0] n = 8'h04);
    wr(LSC_OFF_CTRL, {28'h1, 2'h0, m} & 32'hf | 32'h4);
    burst(n, '{v, v, v}); // uniform white target
    wr(LSC_OFF_CMD, 32'h1);
    q = 32'h100;
    // long enough to outlast the capture timeout
    repeat (800) if (q[LSC_RES_BUSY_BIT]) apb(1'b0, LSC_OFF_RESULT, '0);
    rd(LSC_OFF_RESULT, {29'h0, e});
  endtask : cal
  always @(posedge clk_sys) begin
    if (pready === 1'b1 && rq.size() > 0) begin
      nt = rq.pop_front();
      if (nt.c) cmp_reg(prdata, pslverr, nt);
    end
    if (pov === 1'b1 && pq.size() > 0) cmp_pix(pout, pq.pop_front());
    cyc++;
    if (cyc == 30000) begin
      fail("timeout");
      wrap_up();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    int b;
    logic [15:0] gv;
    lsc_pixel_t v;
    void'($urandom(44));
    foreach (gain[c, k]) gain[c][k] = LSC_UNITY;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(LSC_OFF_CTRL, 32'h4);
    rd(LSC_OFF_RESULT, 32'h0);
    rd(LSC_OFF_GAIN, 32'h4000);
    rd(8'h40, 32'h0, 1'b1);
    for (int k = 0; k < 3; k++) begin
      acq <= k != 0;
      pat <= k == 1;
      wr(LSC_OFF_CTRL, k == 2 ? 32'h0 : 32'h4);
      wr(LSC_OFF_CMD, 32'h1);
      rd(LSC_OFF_RESULT, {29'h0, LSC_RES_ERR3});
    end
    pat <= 1'b0;
    area(32'h4);
    for (int c = 0; c < 3; c++) begin
      b = $urandom % NB;
      gv = 16'($urandom);
      gain[c][b] = gv;
      wr(LSC_OFF_SELECT, {14'h0, 2'(c), 16'(b)});
      wr(LSC_OFF_GAIN, {16'h0, gv});
      rd(LSC_OFF_GAIN, {16'h0, gv});
    end
    v = '{12'($urandom), 12'($urandom), 12'($urandom)};
    for (int p = 0; p < LW; p++)
      pq.push_back('{sat(v.r, gain[0][p/2]), sat(v.g, gain[1][p/2]),
                     sat(v.b, gain[2][p/2])});
    burst(8'h01, v);
    repeat (LW + 4) @(posedge clk_sys);
    cmp_bit(pq.size() == 0, 1'b1);
    wr(LSC_OFF_IRQ_STS, 32'h7);
    wr(LSC_OFF_IRQ_MSK, 32'h4);
    wr(LSC_OFF_CMD, 32'h2);
    repeat (3 * NB + 4) @(posedge clk_sys);
    rd(LSC_OFF_IRQ_STS, 32'h4);
    cmp_bit(irq, 1'b1);
    wr(LSC_OFF_IRQ_STS, 32'h4);
    rd(LSC_OFF_IRQ_STS, 32'h0);
    cmp_bit(irq, 1'b0);
    wr(LSC_OFF_SELECT, 32'h10000);
    wr(LSC_OFF_GAIN, 32'h1234);
    area(32'h8);
    rd(LSC_OFF_GAIN, 32'h4000); // edit dropped, area 2 set
    area(32'h4);
    rd(LSC_OFF_GAIN, {16'h0, gain[1][0]});
    wr(LSC_OFF_REGION, {16'd4, 16'd2}); // narrow region
    cal(LSC_FLAT_FULL, 12'h800, LSC_RES_OK);
    cal(LSC_FLAT_FULL, 12'hfff, LSC_RES_ERR1);
    cal(LSC_COLOR_FULL, 12'h010, LSC_RES_ERR2);
    cal(LSC_FLAT_USER_BE, 12'hfff, LSC_RES_OK_BE);
    cal(LSC_COLOR_USER_BE, 12'h800, LSC_RES_OK_BE);
    // no pixels at all: capture runs into its timeout
    cal(LSC_FLAT_USER_BE, 12'h800, LSC_RES_OK_BE, 8'h00);
    cal(LSC_FLAT_FULL, 12'h800, LSC_RES_ERR2, 8'h00);
    wrap_up();
  end
endmodule : lsc_top_tb_top
